// ===== logic/spcf_pkg.sv
// Package for the serial port clocking and fault block
package spcf_pkg;
   // Register offsets, byte addresses
   localparam logic [3:0] CTRL1_ADDR = 4'h0;
   localparam logic [3:0] CTRL2_ADDR = 4'h4;
   localparam logic [3:0] RATE_ADDR = 4'h8;
   localparam logic [3:0] STATUS_ADDR = 4'hc;
   localparam logic [3:0] TXDATA_ADDR = 4'h0 + 4'h0;
   localparam logic [3:0] DATA_ADDR = 4'h1 << 4'h0;
   // Control register one fields
   localparam int C1_IRQ_EN = 0;
   localparam int C1_MASTER = 1;
   localparam int C1_CLOCK_POLARITY_SEL = 2;
   localparam int C1_CLOCK_PHASE_SEL = 3;
   localparam int C1_SELECT_OUT_EN = 4;
   localparam int C1_LSBF = 5;
   // Control register two fields
   localparam int C2_FAULT_DETECT_EN = 0;
   localparam int C2_BIDIR_OUT_EN = 1;
   localparam int C2_SINGLE = 2;
   // Rate register fields
   localparam int RT_RATE_LSB = 0;
   localparam int RT_PRE_LSB = 4;
   // Status register fields
   localparam int ST_FAULT = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_DONE = 2;
   // Reset values
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] CTRL2_RST = 8'h00;
   localparam logic [7:0] RATE_RST = 8'h00;
   // Bits per transfer, edges per transfer
   localparam logic [4:0] EDGES_8 = 5'h10;
   // Register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } spcf_bus_s;
endpackage

// ===== logic/spcf_core.sv
// Serial port core: clock formats, rate divider, select out, mode fault
// Functional notes
// - Polarity inverts clock; phase picks data timing
// - Phase set: select low half cycle early
// - Phase set: bit one at first edge
// - Phase set: first edge shifts, second samples
// - Phase set slave accepts back-to-back frames
// - Phase clear: select drops at bit one
// - Phase clear: first bit out on select
// - Prescale divisor one through eight
// - Rate divides prescaler by two to 256
// - Rate equals bus over prescale times power
// - Divider runs only for active master transfer
// - Auto select low in transfer, high idle
// - Auto select output disables fault detection
// - Single wire uses MOSI master, MISO slave
// - Output enable gates shared pin drive
// - Clock out as master, in as slave
// - Low select input as master sets fault
// - No fault when detection off or slave
// - Fault makes slave, releases pins, aborts
// - Single wire fault clears output enable
// - Status read then control write clears fault
// - Fault clears master select bit
// - Fault with enable raises interrupt request
module spcf_core (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Register port
   input wire spcf_pkg::spcf_bus_s bus,
   output logic [7:0] rdata,
   // Serial clock pin
   input wire logic sclkIn,
   output logic sclkOut,
   output logic sclkOe_n,
   // Master-out data pin
   input wire logic mosiIn,
   output logic mosiOut,
   output logic mosiOe_n,
   // Master-in data pin
   input wire logic misoIn,
   output logic misoOut,
   output logic misoOe_n,
   // Select pin
   input wire logic selIn_n,
   output logic selOut,
   output logic selOe_n,
   // Request to the interrupt controller
   output logic irqReq
);
   typedef enum logic [1:0] {IDLE, LEAD, RUN, TAIL} spcf_state_e;
   spcf_state_e state_q;
   logic [7:0] ctrl1_q, ctrl2_q, rate_q, tx_q, rx_q, shift_q;
   logic faultFlag_q, faultSeen_q, done_q, startReq_q, sampled_q;
   logic [4:0] edgeCnt_q;
   logic [2:0] preCnt_q;
   logic [7:0] rateCnt_q;
   logic sclkInt_q, selPrev_q, sclkPrev_q;
   logic master, clock_polarity_sel, clock_phase_sel, lsbf, select_out_en, fault_detect_en, single, bidir_out_en;
   logic autoSel, faultDet, faultEv, halfTick, tick, busy;
   logic shiftEdge, sampleEdge, edgeNow, serIn, serOut, slvSel;
   logic [7:0] rateMask;

   // Decoded control bits
   assign master = ctrl1_q[spcf_pkg::C1_MASTER];
   assign clock_polarity_sel = ctrl1_q[spcf_pkg::C1_CLOCK_POLARITY_SEL];
   assign clock_phase_sel = ctrl1_q[spcf_pkg::C1_CLOCK_PHASE_SEL];
   assign lsbf = ctrl1_q[spcf_pkg::C1_LSBF];
   assign select_out_en = ctrl1_q[spcf_pkg::C1_SELECT_OUT_EN];
   assign fault_detect_en = ctrl2_q[spcf_pkg::C2_FAULT_DETECT_EN];
   assign single = ctrl2_q[spcf_pkg::C2_SINGLE];
   assign bidir_out_en = ctrl2_q[spcf_pkg::C2_BIDIR_OUT_EN];
   assign busy = (state_q != IDLE);
   assign slvSel = !master && !selIn_n;

   // Auto select hides the select input from fault detection
   assign autoSel = master && select_out_en && fault_detect_en;
   assign faultDet = master && fault_detect_en && !select_out_en;
   assign faultEv = faultDet && !selIn_n;

   // Prescale counter wraps at setting, rate counter counts ticks modulo 2^rate
   assign rateMask = 8'((9'h002 << rate_q[spcf_pkg::RT_RATE_LSB +: 3]) - 9'h001);
   assign tick = (preCnt_q == rate_q[spcf_pkg::RT_PRE_LSB +: 3]);
   // Half serial clock tick: full divisor is (pre+1)*2^(rate+1)
   assign halfTick = tick && ((rateCnt_q & (rateMask >> 1)) == (rateMask >> 1));

   // Divider runs only while a master transfer is in progress
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         preCnt_q <= 3'h0;
         rateCnt_q <= 8'h00;
      end else if (!(master && busy) || faultEv) begin
         preCnt_q <= 3'h0;
         rateCnt_q <= 8'h00;
      end else if (tick) begin
         preCnt_q <= 3'h0;
         rateCnt_q <= (rateCnt_q + 8'h01) & (rateMask >> 1);
      end else begin
         preCnt_q <= preCnt_q + 3'h1;
      end
   end

   // Control and rate registers; fault clears master select
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctrl1_q <= spcf_pkg::CTRL1_RST;
         ctrl2_q <= spcf_pkg::CTRL2_RST;
         rate_q <= spcf_pkg::RATE_RST;
      end else begin
         if (bus.wr && bus.addr == spcf_pkg::CTRL1_ADDR)
            ctrl1_q <= bus.wdata;
         if (bus.wr && bus.addr == spcf_pkg::CTRL2_ADDR)
            ctrl2_q <= bus.wdata;
         if (bus.wr && bus.addr == spcf_pkg::RATE_ADDR)
            rate_q <= bus.wdata;
         if (faultEv) begin
            ctrl1_q[spcf_pkg::C1_MASTER] <= 1'b0;
            if (single)
               ctrl2_q[spcf_pkg::C2_BIDIR_OUT_EN] <= 1'b0;
         end
      end
   end

   // Fault flag: status read arms, control one write clears; set wins
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         faultFlag_q <= 1'b0;
         faultSeen_q <= 1'b0;
      end else if (faultEv) begin
         faultFlag_q <= 1'b1;
         faultSeen_q <= 1'b0;
      end else if (bus.rd && bus.addr == spcf_pkg::STATUS_ADDR) begin
         faultSeen_q <= faultFlag_q;
      end else if (bus.wr && bus.addr == spcf_pkg::CTRL1_ADDR
                   && faultSeen_q) begin
         faultFlag_q <= 1'b0;
         faultSeen_q <= 1'b0;
      end
   end
   assign irqReq = faultFlag_q && ctrl1_q[spcf_pkg::C1_IRQ_EN];

   // Slave clock edge detect on the raw synchronous pin
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sclkPrev_q <= 1'b0;
         selPrev_q <= 1'b1;
      end else begin
         sclkPrev_q <= sclkIn;
         selPrev_q <= selIn_n;
      end
   end

   // An edge of the serial clock, master or slave
   assign edgeNow = master ? (state_q == RUN && halfTick)
                           : (slvSel && sclkIn != sclkPrev_q);
   // Phase set: odd edges shift, even sample; clear the reverse
   assign shiftEdge = edgeNow && (edgeCnt_q[0] ^ clock_phase_sel);
   assign sampleEdge = edgeNow && !(edgeCnt_q[0] ^ clock_phase_sel);
   // Shared pin carries input in single wire mode
   assign serIn = master ? (single ? mosiIn : misoIn)
                         : (single ? misoIn : mosiIn);
   assign serOut = lsbf ? shift_q[0] : shift_q[7];

   // Transfer request from data write
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         startReq_q <= 1'b0;
      else if (faultEv || !master)
         startReq_q <= 1'b0;
      else if (bus.wr && bus.addr == spcf_pkg::DATA_ADDR)
         startReq_q <= 1'b1;
      else if (state_q == IDLE)
         startReq_q <= 1'b0;
   end

   // Transmit data holding register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         tx_q <= 8'h00;
      else if (bus.wr && bus.addr == spcf_pkg::DATA_ADDR)
         tx_q <= bus.wdata;
   end

   // Frame sequencer: lead half cycle, sixteen edges, tail half cycle
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= IDLE;
         edgeCnt_q <= 5'h00;
         sclkInt_q <= 1'b0;
         shift_q <= 8'h00;
         sampled_q <= 1'b0;
         done_q <= 1'b0;
         rx_q <= 8'h00;
      end else begin
         if (bus.rd && bus.addr == spcf_pkg::STATUS_ADDR)
            done_q <= 1'b0;
         if (faultEv) begin
            state_q <= IDLE;
            edgeCnt_q <= 5'h00;
            sclkInt_q <= 1'b0;
         end else if (!master) begin
            // Select high, or a pending fault, forces slave idle
            if (selIn_n || faultFlag_q) begin
               state_q <= IDLE;
               edgeCnt_q <= 5'h00;
            end else if (selPrev_q || state_q == IDLE) begin
               state_q <= RUN;
               edgeCnt_q <= 5'h00;
               shift_q <= tx_q;
            end
         end else begin
            case (state_q)
               IDLE: begin
                  sclkInt_q <= 1'b0;
                  edgeCnt_q <= 5'h00;
                  if (startReq_q) begin
                     shift_q <= tx_q;
                     state_q <= LEAD;
                  end
               end
               LEAD: if (halfTick) state_q <= RUN;
               RUN: if (halfTick) sclkInt_q <= !sclkInt_q;
               TAIL: if (halfTick) state_q <= IDLE;
               default: state_q <= IDLE;
            endcase
         end
         if (!faultEv && state_q == RUN && edgeNow) begin
            if (sampleEdge)
               sampled_q <= serIn;
            if (shiftEdge && edgeCnt_q != 5'h00)
               shift_q <= lsbf ? {sampled_q, shift_q[7:1]}
                               : {shift_q[6:0], sampled_q};
            edgeCnt_q <= edgeCnt_q + 5'h01;
            if (edgeCnt_q + 5'h01 == spcf_pkg::EDGES_8) begin
               // Last edge completes the byte and latches it
               rx_q <= lsbf ? {sampled_q, shift_q[7:1]}
                            : {shift_q[6:0], sampled_q};
               if (sampleEdge)
                  rx_q <= lsbf ? {serIn, shift_q[7:1]}
                               : {shift_q[6:0], serIn};
               done_q <= 1'b1;
               edgeCnt_q <= 5'h00;
               // Phase set slave stays selected for the next byte
               if (!master)
                  shift_q <= tx_q;
               else
                  // Both phases keep select low for a closing half cycle
                  state_q <= TAIL;
            end
         end
      end
   end

   // Read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         rdata <= 8'h00;
      else if (bus.rd) begin
         case (bus.addr)
            spcf_pkg::CTRL1_ADDR: rdata <= ctrl1_q;
            spcf_pkg::CTRL2_ADDR: rdata <= ctrl2_q;
            spcf_pkg::RATE_ADDR: rdata <= rate_q;
            spcf_pkg::STATUS_ADDR:
               rdata <= {5'h00, done_q, busy, faultFlag_q};
            spcf_pkg::DATA_ADDR: rdata <= rx_q;
            default: rdata <= 8'h00;
         endcase
      end else
         rdata <= 8'h00;
   end

   // Pins: clock out only as master, idle level from polarity
   assign sclkOut = sclkInt_q ^ clock_polarity_sel;
   assign sclkOe_n = !master;
   // Select out low from lead through tail when automatic
   assign selOut = !(autoSel && busy);
   assign selOe_n = !autoSel;
   // Phase set: undefined until first edge, so drive whatever is shifted
   assign mosiOut = serOut;
   assign mosiOe_n = !(master && (!single || bidir_out_en));
   assign misoOut = serOut;
   // Slave buffer stays off after a fault until the flag is cleared
   assign misoOe_n = !(slvSel && !faultFlag_q
                       && (!single || bidir_out_en));

   // Fault always lands the block in slave with pins released
   fault_slave_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      faultEv |=> !master && sclkOe_n && mosiOe_n && state_q == IDLE)
      else $error("Fault did not release the pins");
   fault_flag_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      faultEv |=> faultFlag_q) else $error("Fault flag not set");
   no_fault_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !faultDet |=> !$rose(faultFlag_q))
      else $error("Fault without detect");
   auto_sel_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      autoSel && !busy |-> selOut) else $error("Select low when idle");
   idle_clock_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      master && state_q == IDLE |-> sclkOut == clock_polarity_sel)
      else $error("Idle clock level wrong");
   div_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !(master && busy) |=> preCnt_q == 3'h0)
      else $error("Divider ran while idle");
   fault_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      faultFlag_q && bus.rd && bus.addr == spcf_pkg::STATUS_ADDR ##1
      bus.wr && bus.addr == spcf_pkg::CTRL1_ADDR && !faultEv |=> !faultFlag_q)
      else $error("Fault flag not cleared");
   irq_req_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $rose(faultFlag_q) && ctrl1_q[spcf_pkg::C1_IRQ_EN] |-> irqReq)
      else $error("Fault request missing");
   // Slave data buffer is released while a fault is pending
   fault_miso_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      faultFlag_q |-> misoOe_n)
      else $error("Slave buffer driven during fault");
   // A queued master frame opens with the lead half cycle
   lead_step_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      master && state_q == IDLE && startReq_q && !faultEv |=> state_q == LEAD)
      else $error("Lead half cycle skipped");
   // The sixteenth edge hands over to the closing half cycle
   tail_entry_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      master && state_q == RUN && edgeNow && edgeCnt_q == 5'h0f && !faultEv
      |=> state_q == TAIL)
      else $error("Tail half cycle skipped");
   // The closing half cycle ends after one half period
   tail_exit_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      master && state_q == TAIL && halfTick && !faultEv |=> state_q == IDLE)
      else $error("Tail did not end");
   // Edge counter never passes the byte length
   edge_bound_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      edgeCnt_q < spcf_pkg::EDGES_8)
      else $error("Edge count overran");
   // Slave never drives the serial clock pin
   slave_clock_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !master |-> sclkOe_n)
      else $error("Slave drove the clock");
   // No request reaches the controller without its enable
   irq_mask_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !ctrl1_q[spcf_pkg::C1_IRQ_EN] |-> !irqReq)
      else $error("Request without enable");
endmodule

// ===== verif/spcf_slave_model.sv
// Behavioural slave device on the far side of the serial port
module spcf_slave_model (
   // Serial wires
   input wire logic sclk,
   input wire logic sel_n,
   input wire logic mosi,
   output logic miso,
   // Format and data
   input wire logic clock_phase_sel,
   input wire logic lsbf,
   input wire logic [7:0] txByte,
   output logic [7:0] rxByte
);
   timeunit 1ns;
   timeprecision 1ps;
   int edges = 0;
   function automatic int pos(input int k);
      return lsbf ? k : 7 - k;
   endfunction
   initial miso = 1'b0;
   // Released line shows the inverse so a stale bit never passes
   always @(sel_n) begin
      edges = 0;
      if (!sel_n && !clock_phase_sel) miso = txByte[pos(0)];
      else if (sel_n) miso = ~miso;
   end
   // Both edges counted while selected: one kind samples, other shifts
   always @(sclk) begin
      if (!sel_n) begin
         edges++;
         if (edges[0] != clock_phase_sel) begin
            if ((edges - 1) / 2 < 8) rxByte[pos((edges - 1) / 2)] = mosi;
         end else if (edges / 2 < 8) begin
            miso = txByte[pos(edges / 2)];
         end
      end
   end
endmodule

// ===== verif/test_spcf_core.sv
// Self-checking bench for the serial port core
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module test_spcf_core;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, arst_n, selDrv_n, pCpha, pLsbf, mon;
   spcf_pkg::spcf_bus_s bus;
   logic [7:0] rdata, ptx, prx;
   logic sclkOut, sclkOe_n, mosiOut, mosiOe_n, misoOut, misoOe_n;
   logic selOut, selOe_n, irqReq, pMiso, sclkPrev;
   logic sclkIn, mosiIn, misoIn, selIn_n;
   int fail_count = 0, n_compared = 0, seed = 53, cyc = 0;
   int gap = 0, edgeCnt = 0, expHalf = 1;
   always #12.5 clk_sys = ~clk_sys;
   // Wire levels from every party's enables
   assign sclkIn = sclkOe_n ? ~sclkOut : sclkOut;
   assign mosiIn = mosiOe_n ? ~mosiOut : mosiOut;
   assign misoIn = misoOe_n ? pMiso : misoOut;
   assign selIn_n = selOe_n ? selDrv_n : selOut;
   spcf_core dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .bus(bus),
      .rdata(rdata), .sclkIn(sclkIn), .sclkOut(sclkOut),
      .sclkOe_n(sclkOe_n), .mosiIn(mosiIn), .mosiOut(mosiOut),
      .mosiOe_n(mosiOe_n), .misoIn(misoIn), .misoOut(misoOut),
      .misoOe_n(misoOe_n), .selIn_n(selIn_n), .selOut(selOut),
      .selOe_n(selOe_n), .irqReq(irqReq));
   spcf_slave_model peer_u (.sclk(sclkIn), .sel_n(selIn_n), .mosi(mosiIn),
      .miso(pMiso), .clock_phase_sel(pCpha), .lsbf(pLsbf), .txByte(ptx),
      .rxByte(prx));
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Hang guard, far above the longest frame sequence
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         stop_test;
      end
   end
   // Half periods and select level seen at each clock edge of a frame
   always @(negedge clk_sys) begin
      gap++;
      if (sclkOut !== sclkPrev && mon) begin
         if (edgeCnt > 0) `CHK("halfPeriod", expHalf, gap)
         `CHK("selLow", 1'b0, selOut)
         edgeCnt++;
         gap = 0;
      end
      sclkPrev = sclkOut;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus.wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      @(negedge clk_sys);
      d = rdata;
      @(posedge clk_sys);
   endtask
   initial begin
      logic [7:0] d, tx, c1;
      int m, pre, rt, i, sw;
      bus = '0;
      arst_n = 1'b0;
      selDrv_n = 1'b1;
      {pCpha, pLsbf, mon, ptx} = '0;
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      // Reset values and an unmapped place
      rd(spcf_pkg::CTRL1_ADDR, d); `CHK("ctrl1Rst", spcf_pkg::CTRL1_RST, d)
      rd(spcf_pkg::CTRL2_ADDR, d); `CHK("ctrl2Rst", spcf_pkg::CTRL2_RST, d)
      rd(spcf_pkg::RATE_ADDR, d); `CHK("rateRst", spcf_pkg::RATE_RST, d)
      wr(4'h2, 8'hff);
      rd(4'h2, d); `CHK("unmapped", 8'h00, d)
      $display("test reset done");
      // Every clock format; fastest rate and prescale seven at rate two as corners
      for (m = 0; m < 4; m++) begin
         pre = (m == 0) ? 0 : (m == 3) ? 7 : {$random(seed)} % 8;
         rt = (m == 0) ? 0 : (m == 3) ? 2 : {$random(seed)} % 3;
         expHalf = (pre + 1) << rt;
         pLsbf = $random(seed);
         pCpha = m[1];
         c1 = 8'h12 | {2'b00, pLsbf, 1'b0, m[1], m[0], 2'b00};
         wr(spcf_pkg::CTRL2_ADDR, 8'h01);
         wr(spcf_pkg::RATE_ADDR, 8'((pre << 4) | rt));
         wr(spcf_pkg::CTRL1_ADDR, c1);
         `CHK("idleClk", m[0], sclkOut)
         ptx = $random(seed);
         tx = $random(seed);
         edgeCnt = 0;
         mon = 1'b1;
         wr(spcf_pkg::DATA_ADDR, tx);
         rd(spcf_pkg::STATUS_ADDR, d); `CHK("busy", 1'b1, d[1])
         for (i = 0; i < 1000 && d[1] !== 1'b0; i++)
            rd(spcf_pkg::STATUS_ADDR, d);
         mon = 1'b0;
         `CHK("edges", 16, edgeCnt)
         `CHK("selIdle", 1'b1, selOut)
         `CHK("clkIdle", m[0], sclkOut)
         `CHK("peerRx", tx, prx)
         rd(spcf_pkg::DATA_ADDR, d); `CHK("rx", ptx, d)
      end
      $display("test formats done");
      // Mode fault in normal and single-wire master modes
      for (sw = 0; sw < 2; sw++) begin
         wr(spcf_pkg::CTRL2_ADDR, 8'h01 | 8'(sw * 6));
         wr(spcf_pkg::CTRL1_ADDR, 8'h03);
         @(negedge clk_sys);
         `CHK("misoRel", 1'b1, misoOe_n)
         `CHK("mosiDrv", 1'b0, mosiOe_n)
         `CHK("clkDrv", 1'b0, sclkOe_n)
         @(posedge clk_sys);
         wr(spcf_pkg::DATA_ADDR, 8'($random(seed)));
         repeat (5) @(posedge clk_sys);
         selDrv_n <= 1'b0;
         repeat (3) @(negedge clk_sys);
         `CHK("irq", 1'b1, irqReq)
         `CHK("clkOff", 1'b1, sclkOe_n)
         `CHK("mosiOff", 1'b1, mosiOe_n)
         `CHK("misoOff", 1'b1, misoOe_n)
         @(posedge clk_sys);
         rd(spcf_pkg::STATUS_ADDR, d); `CHK("fault", 2'b01, d[1:0])
         rd(spcf_pkg::CTRL1_ADDR, d); `CHK("mstrClr", 1'b0, d[1])
         rd(spcf_pkg::CTRL2_ADDR, d); `CHK("bidirClr", 1'b0, d[1])
         selDrv_n <= 1'b1;
         rd(spcf_pkg::STATUS_ADDR, d);
         wr(spcf_pkg::CTRL1_ADDR, 8'h02);
         rd(spcf_pkg::STATUS_ADDR, d); `CHK("faultClr", 1'b0, d[0])
         `CHK("irqClr", 1'b0, irqReq)
      end
      $display("test fault done");
      // Select low with detection off, then as slave: no fault
      for (sw = 0; sw < 2; sw++) begin
         wr(spcf_pkg::CTRL2_ADDR, 8'(sw));
         wr(spcf_pkg::CTRL1_ADDR, 8'h01 | 8'((1 - sw) * 2));
         selDrv_n <= 1'b0;
         repeat (3) @(posedge clk_sys);
         rd(spcf_pkg::STATUS_ADDR, d); `CHK("noFault", 1'b0, d[0])
         rd(spcf_pkg::CTRL1_ADDR, d); `CHK("mode", 1'(1 - sw), d[1])
         selDrv_n <= 1'b1;
      end
      $display("test nofault done");
      stop_test;
   end
endmodule
